//--- rtl/srs_regs.svh
/*
 holds register offsets, field positions, reset values and timing counts of the
 reference sync/reset control block.
 assumes inclusion by bare name; definitions only.
*/
// Notes on behaviour
// - sample reference with device clock, align multiframe boundary
// - assertion resets divider, oscillators and multiframe counter
// - assertion is pin rising edge or soft bit rise
// - reference captured on rising sampling clock edge
// - divider reset on every assertion unless masked
// - oscillator and multiframe reset from third assertion
// - programmable delay on reference input path
// - divider mask blocks divider resets while set
// - oscillator/link mask blocks oscillator, multiframe resets
// - reference buffer can be powered down
// - multiframe divide 20K, 4K or DxSxK by mode
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH
// register byte offsets
`define SRS_CTRL_OFF 12'h000
`define SRS_DELAY_OFF 12'h004
`define SRS_MODE_OFF 12'h008
`define SRS_STAT_OFF 12'h00c
// control fields
`define SRS_CTRL_ASSERT 0
`define SRS_CTRL_DIVMASK 1
`define SRS_CTRL_OSCMASK 2
`define SRS_CTRL_PDN 3
// mode fields
`define SRS_MODE_SEL_LO 0
`define SRS_MODE_K_LO 4
`define SRS_MODE_DS_LO 12
// reset values
`define SRS_CTRL_RST 4'h0
`define SRS_DELAY_RST 4'h0
`define SRS_K_RST 8'h10
`define SRS_DS_RST 8'h04
// assertion index from which oscillator and multiframe reset
`define SRS_THIRD 2'h3
// multiframe divide factors per bypass mode
`define SRS_MUL_WIDE 20
`define SRS_MUL_NARROW 4
// lock settling time in ns and cycles at 10 ns
`define SRS_SETTLE_NS 40000
`define SRS_CLK_NS 10
`define SRS_SETTLE_CYC (`SRS_SETTLE_NS / `SRS_CLK_NS)
// axi responses
`define SRS_RESP_OKAY 2'h0
`define SRS_RESP_SLVERR 2'h2
`endif

//--- rtl/srs_pkg.sv
/*
 holds the types of the reference sync/reset control block.
 assumes srs_regs.svh for numeric constants.
*/
package srs_pkg;
  // multiframe clock derivation mode
  typedef enum logic [1:0] {
    srs_bypass_wide,
    srs_bypass_narrow,
    srs_decimate
  } srs_mode_t;
endpackage

//--- rtl/srs_sync_ctrl.sv
/*
 holds the reference sync/reset control block with its axi4-lite register slave.
 assumes inputs synchronous to clk, one aligned 32-bit word per register, and a
 master holding each valid until taken.
*/
`timescale 1ns/1ps
`include "srs_regs.svh"
module srs_sync_ctrl #(
  parameter int DELAY_W = 4,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // reference input pin
  input wire logic ref_in,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset pulses, multiframe tick and buffer power-down to internal blocks
  output logic divider_reset,
  output logic oscillator_reset,
  output logic multiframe_reset,
  output logic multiframe_tick,
  output logic reference_buffer_powerdown
);
  import srs_pkg::*;

  // refuse widths that the 3-bit tap select or the 16-bit length product cannot serve
  if (DELAY_W < 3 || DELAY_W > 8 || CNT_W < 16 || CNT_W > 30) begin : gen_bad_param
    $error("srs_sync_ctrl: unsupported parameter values");
  end

  // whole state of the block
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic soft_reference_assert;
    logic divider_reference_mask;
    logic oscillator_link_reference_mask;
    logic reference_buffer_powerdown;
    logic [DELAY_W-1:0] ref_delay;
    srs_mode_t mode;
    logic [7:0] k;
    logic [7:0] ds;
    logic [7:0] delay_line;
    logic ref_prev;
    logic soft_prev;
    logic [1:0] assert_cnt;
    logic divider_reset;
    logic oscillator_reset;
    logic multiframe_reset;
    logic multiframe_tick;
    logic [CNT_W-1:0] mf_cnt;
    logic [CNT_W-1:0] mf_len;
  } srs_state_t;

  srs_state_t cur;
  srs_state_t next_cur;
  logic delayed_ref; // reference after programmable delay
  logic assertion; // one recognised assertion this cycle
  logic do_write; // write address and data both held

  // tap of the delay line picked by the low bits of the delay register
  always_comb begin
    delayed_ref = cur.delay_line[cur.ref_delay[2:0]];
  end

  // next state
  always_comb begin
    next_cur = cur;
    // sample pin into delay line each rising edge, gated by power-down
    next_cur.delay_line = {cur.delay_line[6:0], ref_in & ~cur.reference_buffer_powerdown};
    next_cur.ref_prev = delayed_ref;
    next_cur.soft_prev = cur.soft_reference_assert;
    // pin rising edge or soft bit 0-to-1
    assertion = (delayed_ref & ~cur.ref_prev) | (cur.soft_reference_assert & ~cur.soft_prev);
    next_cur.divider_reset = assertion & ~cur.divider_reference_mask;
    next_cur.oscillator_reset = 1'b0;
    next_cur.multiframe_reset = 1'b0;
    if (assertion) begin
      // count saturates at three
      if (cur.assert_cnt != `SRS_THIRD) begin
        next_cur.assert_cnt = cur.assert_cnt + 2'h1;
      end
      if (cur.assert_cnt >= 2'h2 && !cur.oscillator_link_reference_mask) begin
        next_cur.oscillator_reset = 1'b1;
        next_cur.multiframe_reset = 1'b1;
      end
    end
    // multiframe length by mode
    unique case (cur.mode)
      srs_bypass_wide: next_cur.mf_len = CNT_W'(`SRS_MUL_WIDE * cur.k);
      srs_bypass_narrow: next_cur.mf_len = CNT_W'(`SRS_MUL_NARROW * cur.k);
      srs_decimate: next_cur.mf_len = CNT_W'(cur.ds * cur.k);
    endcase
    // multiframe counter, boundary realigned by reference
    next_cur.multiframe_tick = 1'b0;
    if (next_cur.multiframe_reset) begin
      next_cur.mf_cnt = '0;
    end else if (cur.mf_cnt + CNT_W'(1) >= cur.mf_len) begin
      next_cur.mf_cnt = '0;
      next_cur.multiframe_tick = 1'b1;
    end else begin
      next_cur.mf_cnt = cur.mf_cnt + CNT_W'(1);
    end
    // write channels taken in either order
    if (s_axi_awvalid && cur.awready) begin
      next_cur.aw_got = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
      next_cur.awready = 1'b0;
    end
    if (s_axi_wvalid && cur.wready) begin
      next_cur.w_got = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_strb = s_axi_wstrb;
      next_cur.wready = 1'b0;
    end
    do_write = cur.aw_got && cur.w_got && !cur.bvalid;
    if (do_write) begin
      next_cur.bvalid = 1'b1;
      next_cur.bresp = `SRS_RESP_OKAY;
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      unique case (cur.aw_addr)
        `SRS_CTRL_OFF: if (cur.w_strb[0]) begin
          next_cur.soft_reference_assert = cur.w_data[`SRS_CTRL_ASSERT];
          next_cur.divider_reference_mask = cur.w_data[`SRS_CTRL_DIVMASK];
          next_cur.oscillator_link_reference_mask = cur.w_data[`SRS_CTRL_OSCMASK];
          next_cur.reference_buffer_powerdown = cur.w_data[`SRS_CTRL_PDN];
        end
        `SRS_DELAY_OFF: if (cur.w_strb[0]) begin
          next_cur.ref_delay = cur.w_data[DELAY_W-1:0];
        end
        `SRS_MODE_OFF: begin
          if (cur.w_strb[0]) begin
            next_cur.mode = (cur.w_data[1:0] == 2'h3) ? srs_decimate : srs_mode_t'(cur.w_data[1:0]);
          end
          if (cur.w_strb[1]) begin
            next_cur.k = cur.w_data[11:4];
          end
          if (cur.w_strb[2]) begin
            next_cur.ds = cur.w_data[19:12];
          end
        end
        `SRS_STAT_OFF: ;
        default: next_cur.bresp = `SRS_RESP_SLVERR;
      endcase
    end
    // response taken, reopen both write channels
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
      next_cur.awready = 1'b1;
      next_cur.wready = 1'b1;
    end
    // read channel
    if (s_axi_arvalid && cur.arready) begin
      next_cur.arready = 1'b0;
      next_cur.rvalid = 1'b1;
      next_cur.rresp = `SRS_RESP_OKAY;
      unique case (s_axi_araddr)
        `SRS_CTRL_OFF: next_cur.rdata = {28'h0, cur.reference_buffer_powerdown,
          cur.oscillator_link_reference_mask, cur.divider_reference_mask, cur.soft_reference_assert};
        `SRS_DELAY_OFF: next_cur.rdata = 32'(cur.ref_delay);
        `SRS_MODE_OFF: next_cur.rdata = {12'h0, cur.ds, cur.k, 2'h0, 2'(cur.mode)};
        `SRS_STAT_OFF: next_cur.rdata = {29'h0, delayed_ref, cur.assert_cnt};
        default: begin
          next_cur.rdata = 32'h0;
          next_cur.rresp = `SRS_RESP_SLVERR;
        end
      endcase
    end
    // read data taken, reopen the address channel
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
      next_cur.arready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
      cur.awready <= 1'b1;
      cur.wready <= 1'b1;
      cur.arready <= 1'b1;
      cur.ref_delay <= DELAY_W'(`SRS_DELAY_RST);
      cur.mode <= srs_bypass_wide;
      cur.k <= `SRS_K_RST;
      cur.ds <= `SRS_DS_RST;
      cur.mf_len <= CNT_W'(`SRS_MUL_WIDE * `SRS_K_RST);
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = cur.awready;
  assign s_axi_wready = cur.wready;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = cur.arready;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign divider_reset = cur.divider_reset;
  assign oscillator_reset = cur.oscillator_reset;
  assign multiframe_reset = cur.multiframe_reset;
  assign multiframe_tick = cur.multiframe_tick;
  assign reference_buffer_powerdown = cur.reference_buffer_powerdown;

  // soft rise with mask clear gives divider reset next cycle
  div_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cur.soft_reference_assert && !cur.soft_prev && !cur.divider_reference_mask) |=> divider_reset)
    else $error("divider reset missing after assertion");
  // mask blocks divider reset
  div_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cur.divider_reference_mask && $stable(cur.divider_reference_mask)) |=> !divider_reset)
    else $error("divider reset despite mask");
  // oscillator reset only after two earlier assertions
  osc_third_a: assert property (@(posedge clk) disable iff (!arst_n)
    oscillator_reset |-> $past(cur.assert_cnt) >= 2'h2)
    else $error("oscillator reset before third assertion");
  // oscillator mask blocks reset
  osc_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    $past(cur.oscillator_link_reference_mask) |-> !oscillator_reset)
    else $error("oscillator reset despite mask");
  // multiframe and oscillator resets go together
  mf_pair_a: assert property (@(posedge clk) disable iff (!arst_n)
    oscillator_reset == multiframe_reset)
    else $error("oscillator and multiframe reset differ");
  // counter never decreases
  cnt_sat_a: assert property (@(posedge clk) disable iff (!arst_n)
    cur.assert_cnt >= $past(cur.assert_cnt))
    else $error("assertion counter went down");
  // multiframe counter restarts after reset
  mf_align_a: assert property (@(posedge clk) disable iff (!arst_n)
    multiframe_reset |-> cur.mf_cnt == '0)
    else $error("multiframe boundary not realigned");
  // power-down blanks pin input
  pdn_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    reference_buffer_powerdown |=> !cur.delay_line[0])
    else $error("reference passed while powered down");
  // pin edge at the tap with mask clear gives divider reset next cycle
  pin_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
    (delayed_ref && !cur.ref_prev && !cur.divider_reference_mask) |=> divider_reset)
    else $error("divider reset missing after pin edge");
  // third and later assertions reset oscillator and multiframe
  osc_fire_a: assert property (@(posedge clk) disable iff (!arst_n)
    (assertion && cur.assert_cnt >= 2'h2 && !cur.oscillator_link_reference_mask) |=>
    (oscillator_reset && multiframe_reset))
    else $error("oscillator reset missing from third assertion");
  // each assertion steps the count until it saturates
  cnt_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (assertion && cur.assert_cnt != 2'h3) |=> (cur.assert_cnt == $past(cur.assert_cnt) + 2'h1))
    else $error("assertion count did not step");
  // count moves only on an assertion
  cnt_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !assertion |=> $stable(cur.assert_cnt))
    else $error("assertion count moved without assertion");
  // multiframe tick only where the count reaches the length
  tick_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    multiframe_tick |-> ($past(cur.mf_cnt) + CNT_W'(1) >= $past(cur.mf_len)))
    else $error("multiframe tick before end of length");
  // write address closes once taken
  aw_lock_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s_axi_awvalid && s_axi_awready) |=> !s_axi_awready)
    else $error("write address still open after take");
  // read answer follows the address take
  rd_answer_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s_axi_arvalid && s_axi_arready) |=> (s_axi_rvalid && !s_axi_arready))
    else $error("read answer missing after address take");
  // response taken reopens both write channels
  wr_reopen_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s_axi_bvalid && s_axi_bready) |=> (!s_axi_bvalid && s_axi_awready && s_axi_wready))
    else $error("write channels not reopened");
endmodule

//--- sim/srs_ref_gen.sv
/*
 holds a model of the external reference source driving the reference pin.
 assumes one clock shared with the block and shot requests from the bench.
*/
`timescale 1ns/1ps
module srs_ref_gen #(
  parameter int SETTLE_CYC = 320,
  parameter int HIGH_CYC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // shot request from the bench
  input wire logic fire,
  input wire logic [3:0] shots,
  input wire logic [15:0] period,
  // reference pin and status
  output logic ref_out,
  output logic busy
);
  logic [3:0] left; // shots still owed
  logic [15:0] t; // cycles into this interval
  logic first; // first interval carries the lock settle wait
  logic [15:0] span; // length of the current interval
  // period rounded to 64 cycles, settle added after the first shot
  assign span = {period[15:6], 6'h00} + (first ? 16'(SETTLE_CYC) : 16'h0000);
  assign busy = (left != 4'h0);
  // shot sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      left <= 4'h0;
      t <= 16'h0000;
      first <= 1'b0;
      ref_out <= 1'b0;
    end else if (fire) begin
      // reference is started before any register is programmed
      left <= shots;
      t <= 16'h0000;
      first <= 1'b1;
    end else if (busy) begin
      ref_out <= (t < 16'(HIGH_CYC));
      if (t == span - 16'h0001) begin
        t <= 16'h0000;
        first <= 1'b0;
        left <= left - 4'h1;
      end else begin
        t <= t + 16'h0001;
      end
    end else begin
      // reference stopped once the shots are spent
      ref_out <= 1'b0;
    end
  end
endmodule

//--- sim/tb_top.sv
/*
 holds the self-checking bench of the reference sync/reset block.
 assumes srs_sync_ctrl and srs_ref_gen are compiled before it.
*/
`timescale 1ns/1ps
`include "srs_regs.svh"
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, shots = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fire = 1'b0, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic ref_in, divider_reset, oscillator_reset, multiframe_reset, multiframe_tick, reference_buffer_powerdown;
  logic ref_q = 1'b0;
  int err_count = 0, checks = 0, cyc = 0, n_div = 0, n_osc = 0, n_mf = 0, n_tick = 0;
  int t_rise = 0, t_div = 0, t_tick = 0, t_gap = 0, b_div, b_osc, b_mf, k;
  // read table: address, data, response
  logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
  logic [31:0] rx [5] = '{32'h0, 32'h0, 32'h4100, 32'h3, 32'h0};
  logic [1:0] rr [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  // mode table and control table
  logic [31:0] mv [3] = '{32'h4101, 32'h8102, 32'h4100};
  int mg [3] = '{64, 128, 320};
  logic [31:0] cv [3] = '{32'h2, 32'h4, 32'h8};
  int cd [3] = '{0, 1, 0};
  int co [3] = '{1, 0, 0};
  // device and far side
  srs_sync_ctrl srs_sync_ctrl_inst (.clk, .arst_n, .ref_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .divider_reset, .oscillator_reset, .multiframe_reset, .multiframe_tick, .reference_buffer_powerdown);
  // settle wait just over the lock time; period one wide multiframe, a multiple of 64
  srs_ref_gen #(.SETTLE_CYC(`SRS_SETTLE_CYC + 1)) srs_ref_gen_inst (.clk, .arst_n, .fire, .shots,
    .period(16'h0140), .ref_out(ref_in), .busy);
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  // pulse counters, latency and tick spacing, timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ref_q <= ref_in;
    if (ref_in && !ref_q) t_rise <= cyc;
    if (divider_reset) t_div <= cyc;
    n_div <= n_div + int'(divider_reset);
    n_osc <= n_osc + int'(oscillator_reset);
    n_mf <= n_mf + int'(multiframe_reset);
    if (multiframe_tick) begin
      t_gap <= cyc - t_tick;
      t_tick <= cyc;
      n_tick <= n_tick + 1;
    end
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdw(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic snap;
    b_div = n_div;
    b_osc = n_osc;
    b_mf = n_mf;
  endtask
  // ask the far side for shots, wait until done plus tap latency
  task automatic shoot(input logic [3:0] n);
    snap();
    @(posedge clk);
    fire <= 1'b1;
    shots <= n;
    @(posedge clk);
    fire <= 1'b0;
    do @(posedge clk); while (busy);
    repeat (12) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("err_count %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    shoot(4'h3);
    chk(n_div - b_div, 3);
    chk(n_osc - b_osc, 1);
    chk(n_mf - b_mf, 1);
    for (int i = 0; i < 5; i++) begin
      rdw(ra[i]);
      chk(rd, rx[i]);
      chk(rsp, rr[i]);
    end
    wr(`SRS_STAT_OFF, 32'h0);
    chk(rsp, 32'h0);
    wr(12'h010, 32'h1);
    chk(rsp, 32'h2);
    rdw(`SRS_STAT_OFF);
    chk(rd, 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(`SRS_MODE_OFF, mv[i]);
      k = n_tick;
      do @(posedge clk); while (n_tick < k + 2);
      chk(t_gap, mg[i]);
    end
    wr(`SRS_DELAY_OFF, 32'h3);
    shoot(4'h1);
    chk(t_div - t_rise, 5);
    chk(n_osc - b_osc, 1);
    wr(`SRS_DELAY_OFF, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`SRS_CTRL_OFF, cv[i]);
      shoot(4'h1);
      chk(n_div - b_div, cd[i]);
      chk(n_osc - b_osc, co[i]);
      chk(n_mf - b_mf, co[i]);
    end
    chk(reference_buffer_powerdown, 1'b1);
    wr(`SRS_CTRL_OFF, 32'h0);
    snap();
    wr(`SRS_CTRL_OFF, 32'h1);
    repeat (4) @(posedge clk);
    chk(n_div - b_div, 1);
    chk(n_osc - b_osc, 1);
    snap();
    wr(`SRS_CTRL_OFF, 32'h1);
    repeat (4) @(posedge clk);
    chk(n_div - b_div, 0);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rdw(`SRS_STAT_OFF);
    chk(rd, 32'h0);
    shoot(4'h1);
    chk(n_div - b_div, 1);
    chk(n_osc - b_osc, 0);
    wrap_up();
  end
endmodule
